// *** core/brs_sequencer.sv ***
// Purpose: Shot sequencer of a feeder auto-reclose function
// Assumes: Requests and breaker status come from logic on SYS_CLK
// Notes:   Times are in 0.5 ms ticks; lowest request index wins
// Summary of operation
// - Each request and shot has an enable, default off; disabled shots are skipped.
// - Request must stay active for the shot starting delay before opening.
// - Starting delay applies only to requests from a start signal, not trips.
// - Nonzero trip-request starting delay of the stage blocks the sequence start.
// - Dead time runs from breaker open; at expiry the breaker is closed.
// - Per-shot arcing or discrimination; arcing holds breaker closed through action time.
// - New request during action time of an arcing shot locks the function for the reclaim period.
// - Zero action time disables the interval; else it runs alongside reclaim.
// - Shot reclaim timer starts once the breaker is closed after dead time.
// - New request during shot reclaim fails the shot; move to next shot.
// - Failure of the last enabled shot issues the final trip.
// - Whenever not ready, a status code gives the reason.
// - Inhibit on block, disable, lock-out, command block, bad status, general reclaim, lock.
// - Inhibit returns to ready as soon as all its causes clear.
// - Lock on lock input, final trip or breaker failure.
// - A request during general reclaim locks the function.
// - A request not released by the end of dead time locks the function.
// - A critical request locks the function in any state.
// - Leave locked only by reset input, any breaker close or reset command, as configured.
// - Reset choices: user signal, any breaker close, or command; default user.
// - After success run lock-out time; request during it opens and locks.
`timescale 1ns/1ps
`default_nettype none
module brs_sequencer #(
	parameter int unsigned NREQ        = brs_pkg::NREQ,
	parameter int unsigned NSHOT       = brs_pkg::NSHOT,
	parameter int unsigned TICK_CYCLES = brs_pkg::TICK_CYCLES
) (
	input  wire logic                                    SYS_CLK,
	input  wire logic                                    RSTN,
	input  wire logic [NREQ-1:0][NSHOT-1:0]              SHOT_EN,
	input  wire logic [NREQ-1:0][NSHOT-1:0]              SHOT_DISCR,
	input  wire logic [NREQ-1:0][NSHOT-1:0][brs_pkg::TW-1:0] SHOT_START_DLY,
	input  wire logic [NREQ-1:0][NSHOT-1:0][brs_pkg::TW-1:0] SHOT_DEAD,
	input  wire logic [NREQ-1:0][NSHOT-1:0][brs_pkg::TW-1:0] SHOT_ACTION,
	input  wire logic [NREQ-1:0][NSHOT-1:0][brs_pkg::TW-1:0] SHOT_RECLAIM,
	input  wire logic [brs_pkg::TW-1:0]                  LOCKOUT_TIME,
	input  wire logic [brs_pkg::TW-1:0]                  GEN_RECLAIM_TIME,
	input  wire logic                                    GEN_RECLAIM_EN,
	input  wire logic [1:0]                              RESET_MODE,
	input  wire logic [NREQ-1:0]                         REQ_START,
	input  wire logic [NREQ-1:0]                         REQ_TRIP,
	input  wire logic [NREQ-1:0]                         TRIP_DELAY_NZ,
	input  wire logic                                    CRIT_REQ,
	input  wire logic                                    BLOCK_IN,
	input  wire logic                                    RECLOSE_ENABLE_INPUT,
	input  wire logic                                    LOCK_INPUT,
	input  wire logic                                    RESET_IN,
	input  wire logic                                    RESET_CMD,
	input  wire logic                                    OBJ_CLOSE_ANY,
	input  wire logic                                    OBJ_MAN_CLOSE,
	input  wire logic                                    OBJ_CMD_BLOCKED,
	input  wire logic                                    OBJ_OPEN,
	input  wire logic                                    OBJ_CLOSED,
	input  wire logic                                    OBJ_BAD,
	input  wire logic                                    OBJ_FAULT,
	output logic                                         OPEN_CMD,
	output logic                                         CLOSE_CMD,
	output logic                                         FINAL_TRIP,
	output logic                                         READY,
	output logic                                         INHIBIT,
	output logic                                         LOCKED,
	output logic                                         RUNNING,
	output logic [NSHOT-1:0]                             SHOT_EXEC,
	output logic [2:0]                                   REQ_SEL,
	output logic [3:0]                                   REASON
);
	localparam int unsigned TW = brs_pkg::TW;

	if (NREQ < 1 || NREQ > 8 || NSHOT < 1 || NSHOT > 7) begin : g_chk
		$error("brs_sequencer: request or shot count out of range");
	end

	typedef struct packed {
		brs_pkg::brs_state_t  state;
		brs_pkg::brs_reason_t lock_why;
		brs_pkg::brs_reason_t reason;
		logic [2:0]           req;
		logic [2:0]           shot;
		logic                 src_trip;
		logic                 act_run;
		logic                 arc_lock;
		logic                 open_cmd;
		logic                 close_cmd;
		logic                 final_trip;
		logic                 ready;
		logic                 inhibit;
		logic                 locked;
		logic                 running;
		logic [NSHOT-1:0]     shot_exec;
	} brs_st_t;

	brs_st_t st;
	brs_st_t next_st;

	brs_tmr_if #(.N(2), .W(TW)) tm ();

	brs_timers #(.N(2), .W(TW), .TICK_CYCLES(TICK_CYCLES)) u_timers (
		.clk  (SYS_CLK),
		.rstn (RSTN),
		.t    (tm.tmr)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Returns {found, index} of the first enabled shot at or after from
	function automatic logic [3:0] first_shot(input logic [NSHOT-1:0] en, input logic [3:0] from);
		logic [3:0] r;
		r = 4'h0;
		for (int i = NSHOT - 1; i >= 0; i--) begin
			if (en[i] && (4'(i) >= from)) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : first_shot

	logic                 req_any;
	logic                 inh_in;
	logic                 go_shot;
	logic                 lock_now;
	logic                 rst_ok;
	brs_pkg::brs_reason_t lock_why;
	logic [3:0]           fnd;
	logic [2:0]           r;

	// ****************************************
	// Sequence
	// ****************************************
	always_comb begin
		next_st   = st;
		tm.load   = '0;
		tm.clear  = '0;
		tm.value  = '0;
		go_shot   = 1'b0;
		lock_now  = 1'b0;
		lock_why  = brs_pkg::R_NONE;
		fnd       = 4'h0;
		r         = 3'h0;
		req_any   = |(REQ_START | REQ_TRIP);
		inh_in    = BLOCK_IN | !RECLOSE_ENABLE_INPUT | OBJ_CMD_BLOCKED | OBJ_BAD;
		unique case (RESET_MODE)
			brs_pkg::RM_CLOSE: rst_ok = OBJ_CLOSE_ANY;
			brs_pkg::RM_CMD:   rst_ok = RESET_CMD;
			default:           rst_ok = RESET_IN;
		endcase
		unique case (st.state)
			brs_pkg::S_IDLE: begin
				if (OBJ_MAN_CLOSE) begin
					next_st.state     = brs_pkg::S_GREC;
					tm.load[brs_pkg::TM_MAIN]  = 1'b1;
					tm.value[brs_pkg::TM_MAIN] = GEN_RECLAIM_TIME;
				end else if (!inh_in && req_any) begin
					for (int i = NREQ - 1; i >= 0; i--) begin
						if (REQ_START[i] || REQ_TRIP[i]) begin
							r = 3'(i);
						end
					end
					fnd = first_shot(SHOT_EN[r], 4'h0);
					// Stage with a trip starting delay never starts a cycle
					if (!TRIP_DELAY_NZ[r] && fnd[3]) begin
						next_st.req      = r;
						next_st.shot     = fnd[2:0];
						next_st.src_trip = !REQ_START[r];
						go_shot          = 1'b1;
					end
				end
			end
			brs_pkg::S_START: begin
				if (!REQ_START[st.req]) begin
					next_st.state = brs_pkg::S_IDLE;
					tm.clear[brs_pkg::TM_MAIN] = 1'b1;
				end else if (tm.expired[brs_pkg::TM_MAIN]) begin
					next_st.state    = brs_pkg::S_OPEN;
					next_st.open_cmd = 1'b1;
				end
			end
			brs_pkg::S_OPEN: begin
				if (OBJ_OPEN) begin
					next_st.open_cmd = 1'b0;
					next_st.state    = brs_pkg::S_DEAD;
					tm.load[brs_pkg::TM_MAIN]  = 1'b1;
					tm.value[brs_pkg::TM_MAIN] = SHOT_DEAD[st.req][st.shot];
				end
			end
			brs_pkg::S_DEAD: begin
				if (tm.expired[brs_pkg::TM_MAIN]) begin
					if (req_any) begin
						lock_now = 1'b1;
						lock_why = brs_pkg::R_NOT_REL;
					end else begin
						next_st.close_cmd = 1'b1;
						next_st.state     = brs_pkg::S_CLOSE;
					end
				end
			end
			brs_pkg::S_CLOSE: begin
				if (OBJ_CLOSED) begin
					next_st.close_cmd = 1'b0;
					next_st.state     = brs_pkg::S_RECL;
					tm.load[brs_pkg::TM_MAIN]  = 1'b1;
					tm.value[brs_pkg::TM_MAIN] = SHOT_RECLAIM[st.req][st.shot];
					if (SHOT_ACTION[st.req][st.shot] != '0) begin
						next_st.act_run = 1'b1;
						tm.load[brs_pkg::TM_ACT]  = 1'b1;
						tm.value[brs_pkg::TM_ACT] = SHOT_ACTION[st.req][st.shot];
					end
				end
			end
			brs_pkg::S_RECL: begin
				if (tm.expired[brs_pkg::TM_ACT]) begin
					next_st.act_run = 1'b0;
				end
				if (req_any && !st.arc_lock) begin
					if (st.act_run && !SHOT_DISCR[st.req][st.shot]) begin
						// Arcing keeps the breaker closed; locked until reclaim ends
						next_st.arc_lock = 1'b1;
					end else begin
						tm.clear        = 2'b11;
						next_st.act_run = 1'b0;
						fnd = first_shot(SHOT_EN[st.req], 4'(st.shot) + 4'h1);
						if (fnd[3]) begin
							next_st.shot = fnd[2:0];
							go_shot      = 1'b1;
						end else begin
							lock_now = 1'b1;
							lock_why = brs_pkg::R_FINAL;
						end
					end
				end else if (tm.expired[brs_pkg::TM_MAIN]) begin
					next_st.act_run  = 1'b0;
					next_st.arc_lock = 1'b0;
					tm.clear[brs_pkg::TM_ACT] = 1'b1;
					if (LOCKOUT_TIME != '0) begin
						next_st.state = brs_pkg::S_LOUT;
						tm.load[brs_pkg::TM_MAIN]  = 1'b1;
						tm.value[brs_pkg::TM_MAIN] = LOCKOUT_TIME;
					end else if (GEN_RECLAIM_EN) begin
						next_st.state = brs_pkg::S_GREC;
						tm.load[brs_pkg::TM_MAIN]  = 1'b1;
						tm.value[brs_pkg::TM_MAIN] = GEN_RECLAIM_TIME;
					end else begin
						next_st.state = brs_pkg::S_IDLE;
					end
				end
			end
			brs_pkg::S_LOUT: begin
				if (req_any) begin
					lock_now         = 1'b1;
					lock_why         = brs_pkg::R_LOUT_REQ;
					next_st.open_cmd = 1'b1;
				end else if (tm.expired[brs_pkg::TM_MAIN]) begin
					next_st.state = brs_pkg::S_IDLE;
				end
			end
			brs_pkg::S_GREC: begin
				if (req_any) begin
					lock_now = 1'b1;
					lock_why = brs_pkg::R_GREC_REQ;
				end else if (tm.expired[brs_pkg::TM_MAIN]) begin
					next_st.state = brs_pkg::S_IDLE;
				end
			end
			brs_pkg::S_LOCK: begin
				if (OBJ_OPEN) begin
					next_st.open_cmd = 1'b0;
				end
				if (rst_ok && !LOCK_INPUT && !CRIT_REQ && !OBJ_FAULT) begin
					next_st.state      = brs_pkg::S_IDLE;
					next_st.final_trip = 1'b0;
					next_st.open_cmd   = 1'b0;
					next_st.lock_why   = brs_pkg::R_NONE;
				end
			end
			default: begin
				next_st.state = brs_pkg::S_IDLE;
			end
		endcase
		// Zero starting delay or trip source opens at once
		if (go_shot) begin
			if (next_st.src_trip || SHOT_START_DLY[next_st.req][next_st.shot] == '0) begin
				next_st.state    = brs_pkg::S_OPEN;
				next_st.open_cmd = 1'b1;
			end else begin
				next_st.state = brs_pkg::S_START;
				// A failed shot clears both timers; clear outranks load in the timers
				tm.clear[brs_pkg::TM_MAIN] = 1'b0;
				tm.load[brs_pkg::TM_MAIN]  = 1'b1;
				tm.value[brs_pkg::TM_MAIN] = SHOT_START_DLY[next_st.req][next_st.shot];
			end
		end
		// Global lock causes override any position in the cycle
		if (st.state != brs_pkg::S_LOCK) begin
			if (CRIT_REQ) begin
				lock_now = 1'b1;
				lock_why = brs_pkg::R_CRIT;
			end else if (LOCK_INPUT) begin
				lock_now = 1'b1;
				lock_why = brs_pkg::R_LOCK_IN;
			end else if (OBJ_FAULT) begin
				lock_now = 1'b1;
				lock_why = brs_pkg::R_OBJ_FAIL;
			end
		end
		if (lock_now) begin
			next_st.state     = brs_pkg::S_LOCK;
			next_st.lock_why  = lock_why;
			next_st.close_cmd = 1'b0;
			next_st.act_run   = 1'b0;
			next_st.arc_lock  = 1'b0;
			tm.clear          = 2'b11;
			tm.load           = 2'b00;
			if (lock_why == brs_pkg::R_FINAL) begin
				next_st.final_trip = 1'b1;
				next_st.open_cmd   = 1'b1;
			end
		end
		// Status outputs follow the next state
		next_st.locked  = (next_st.state == brs_pkg::S_LOCK) || next_st.arc_lock;
		next_st.inhibit = inh_in || next_st.locked ||
			next_st.state == brs_pkg::S_LOUT || next_st.state == brs_pkg::S_GREC;
		next_st.ready   = !next_st.inhibit;
		next_st.running = !(next_st.state inside {brs_pkg::S_IDLE, brs_pkg::S_LOCK,
			brs_pkg::S_LOUT, brs_pkg::S_GREC});
		next_st.shot_exec = next_st.running ? (NSHOT'(1) << next_st.shot) : '0;
		if (next_st.state == brs_pkg::S_LOCK) begin
			next_st.reason = next_st.lock_why;
		end else if (next_st.arc_lock) begin
			next_st.reason = brs_pkg::R_ARC_LOCK;
		end else if (BLOCK_IN) begin
			next_st.reason = brs_pkg::R_BLOCKED;
		end else if (!RECLOSE_ENABLE_INPUT) begin
			next_st.reason = brs_pkg::R_DISABLED;
		end else if (next_st.state == brs_pkg::S_LOUT) begin
			next_st.reason = brs_pkg::R_LOUT;
		end else if (OBJ_CMD_BLOCKED) begin
			next_st.reason = brs_pkg::R_CMD_BLK;
		end else if (OBJ_BAD) begin
			next_st.reason = brs_pkg::R_OBJ_BAD;
		end else if (next_st.state == brs_pkg::S_GREC) begin
			next_st.reason = brs_pkg::R_GREC;
		end else begin
			next_st.reason = brs_pkg::R_NONE;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st          <= '0;
			st.state    <= brs_pkg::RST_STATE;
			st.lock_why <= brs_pkg::RST_REASON;
			st.reason   <= brs_pkg::R_DISABLED;
			st.inhibit  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign OPEN_CMD   = st.open_cmd;
	assign CLOSE_CMD  = st.close_cmd;
	assign FINAL_TRIP = st.final_trip;
	assign READY      = st.ready;
	assign INHIBIT    = st.inhibit;
	assign LOCKED     = st.locked;
	assign RUNNING    = st.running;
	assign SHOT_EXEC  = st.shot_exec;
	assign REQ_SEL    = st.req;
	assign REASON     = st.reason;

	// ****************************************
	// Checks
	// ****************************************
	AST_SHOT_ENABLED: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		RUNNING |-> SHOT_EN[st.req][st.shot])
		else $error("disabled shot executing");
	AST_TRIP_NO_DELAY: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		st.state == brs_pkg::S_START |-> !st.src_trip)
		else $error("start delay counted for trip request");
	AST_DEAD_CLOSE: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(st.state == brs_pkg::S_DEAD && tm.expired[0] && !req_any && !CRIT_REQ
		&& !LOCK_INPUT && !OBJ_FAULT) |=> CLOSE_CMD && st.state == brs_pkg::S_CLOSE)
		else $error("no close at dead time expiry");
	AST_NOT_RELEASED: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(st.state == brs_pkg::S_DEAD && tm.expired[0] && req_any) |=> LOCKED && !CLOSE_CMD)
		else $error("unreleased request did not lock");
	AST_FINAL_TRIP: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		$rose(FINAL_TRIP) |-> LOCKED && OPEN_CMD && REASON == brs_pkg::R_FINAL)
		else $error("final trip without lock and open");
	AST_CRITICAL: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		CRIT_REQ |=> LOCKED && !RUNNING)
		else $error("critical request did not lock");
	AST_BLOCK_INHIBIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(BLOCK_IN || !RECLOSE_ENABLE_INPUT) |=> INHIBIT && !READY)
		else $error("inhibit not shown");
	AST_READY_BACK: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(st.state == brs_pkg::S_IDLE && !inh_in && !req_any && !OBJ_MAN_CLOSE
		&& !CRIT_REQ && !LOCK_INPUT && !OBJ_FAULT) |=> READY && REASON == brs_pkg::R_NONE)
		else $error("ready not restored");
	AST_GREC_LOCK: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(st.state == brs_pkg::S_GREC && req_any) |=> LOCKED)
		else $error("request in general reclaim did not lock");
	AST_ONE_SHOT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		$onehot0(SHOT_EXEC) && (RUNNING == (SHOT_EXEC != '0)))
		else $error("more than one shot executing");
	AST_LOCK_EXIT: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		(st.state == brs_pkg::S_LOCK && !rst_ok) |=> st.state == brs_pkg::S_LOCK)
		else $error("lock left without configured reset");
	AST_NOT_READY_REASON: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
		!READY |-> REASON != brs_pkg::R_NONE)
		else $error("not ready without reason");
endmodule : brs_sequencer
`default_nettype wire

// *** core/brs_pkg.sv ***
// Purpose: Shared constants and types of the reclose shot sequencer
// Assumes: 20 MHz system clock, timers counted in 0.5 ms ticks
// Notes:   All time settings are given to the block in ticks
package brs_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TICK_NS       = 500_000;
	localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TW            = 22;
	localparam int unsigned NREQ          = 5;
	localparam int unsigned NSHOT         = 5;
	localparam int unsigned TM_MAIN       = 0;
	localparam int unsigned TM_ACT        = 1;

	// ****************************************
	// Manual resetting choices
	// ****************************************
	localparam logic [1:0] RM_USER  = 2'h0;
	localparam logic [1:0] RM_CLOSE = 2'h1;
	localparam logic [1:0] RM_CMD   = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_START = 4'h1,
		S_OPEN  = 4'h2,
		S_DEAD  = 4'h3,
		S_CLOSE = 4'h4,
		S_RECL  = 4'h5,
		S_LOUT  = 4'h6,
		S_GREC  = 4'h7,
		S_LOCK  = 4'h8
	} brs_state_t;

	typedef enum logic [3:0] {
		R_NONE     = 4'h0,
		R_BLOCKED  = 4'h1,
		R_DISABLED = 4'h2,
		R_LOUT     = 4'h3,
		R_CMD_BLK  = 4'h4,
		R_OBJ_BAD  = 4'h5,
		R_GREC     = 4'h6,
		R_LOCK_IN  = 4'h7,
		R_FINAL    = 4'h8,
		R_OBJ_FAIL = 4'h9,
		R_GREC_REQ = 4'hA,
		R_NOT_REL  = 4'hB,
		R_CRIT     = 4'hC,
		R_LOUT_REQ = 4'hD,
		R_ARC_LOCK = 4'hE
	} brs_reason_t;

	localparam brs_state_t  RST_STATE  = S_IDLE;
	localparam brs_reason_t RST_REASON = R_NONE;
endpackage : brs_pkg

// *** core/brs_tmr_if.sv ***
// Purpose: Carrier between sequencer and its tick timers
// Assumes: One load or clear per timer per cycle
// Notes:   expired is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface brs_tmr_if #(
	parameter int unsigned N = 2,
	parameter int unsigned W = 22
);
	logic [N-1:0]        load;
	logic [N-1:0]        clear;
	logic [N-1:0][W-1:0] value;
	logic [N-1:0]        expired;

	modport ctl (output load, output clear, output value, input expired);
	modport tmr (input load, input clear, input value, output expired);
endinterface : brs_tmr_if
`default_nettype wire

// *** core/brs_timers.sv ***
// Purpose: Down-counting tick timers of the sequencer
// Assumes: Value counts 0.5 ms ticks; zero expires on the next cycle
// Notes:   Each timer owns its prescaler so no time runs short
`timescale 1ns/1ps
`default_nettype none
module brs_timers #(
	parameter int unsigned N           = 2,
	parameter int unsigned W           = brs_pkg::TW,
	parameter int unsigned TICK_CYCLES = brs_pkg::TICK_CYCLES
) (
	input  wire logic clk,
	input  wire logic rstn,
	brs_tmr_if.tmr    t
);
	localparam int unsigned PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	if (TICK_CYCLES < 2 || N < 1) begin : g_chk
		$error("brs_timers: unsupported parameters");
	end

	typedef struct packed {
		logic [N-1:0][PW-1:0] pre;
		logic [N-1:0][W-1:0]  cnt;
		logic [N-1:0]         run;
		logic [N-1:0]         exp;
	} brs_tst_t;

	brs_tst_t st;
	brs_tst_t next_st;

	// ****************************************
	// Count
	// ****************************************
	always_comb begin
		next_st = st;
		for (int i = 0; i < N; i++) begin
			next_st.exp[i] = 1'b0;
			if (t.clear[i]) begin
				next_st.run[i] = 1'b0;
				next_st.cnt[i] = '0;
				next_st.pre[i] = '0;
			end else if (t.load[i]) begin
				next_st.pre[i] = '0;
				next_st.cnt[i] = t.value[i];
				next_st.run[i] = (t.value[i] != '0);
				next_st.exp[i] = (t.value[i] == '0);
			end else if (st.run[i]) begin
				if (st.pre[i] == PW'(TICK_CYCLES - 1)) begin
					next_st.pre[i] = '0;
					next_st.cnt[i] = st.cnt[i] - W'(1);
					if (st.cnt[i] == W'(1)) begin
						next_st.run[i] = 1'b0;
						next_st.exp[i] = 1'b1;
					end
				end else begin
					next_st.pre[i] = st.pre[i] + PW'(1);
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign t.expired = st.exp;

	AST_TMR_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
		t.clear[0] |=> !st.run[0] && !st.exp[0])
		else $error("timer kept running after clear");
endmodule : brs_timers
`default_nettype wire

// *** verification/brs_breaker_model.sv ***
// Purpose: Breaker object model on the far side of the sequencer
// Assumes: Open and close commands are levels held until the status follows
// Notes:   Moves after DLY+1 cycles; both status bits low while moving
`timescale 1ns/1ps
`default_nettype none
module brs_breaker_model #(
	parameter int unsigned DLY = 3
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic open_cmd,
	input  wire logic close_cmd,
	output var logic  obj_open,
	output var logic  obj_closed
);
	int cnt;
	// Mid-stroke neither contact reports, so a stale status never leaks through
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt        <= 0;
			obj_open   <= 1'b0;
			obj_closed <= 1'b1;
		end else if ((open_cmd && !obj_open) || (close_cmd && !obj_closed)) begin
			cnt        <= cnt + 1;
			obj_open   <= 1'b0;
			obj_closed <= 1'b0;
			if (cnt == DLY) begin
				cnt        <= 0;
				obj_open   <= open_cmd;
				obj_closed <= close_cmd;
			end
		end
	end
endmodule : brs_breaker_model
`default_nettype wire

// *** verification/brs_sequencer_tb.sv ***
// Purpose: Self-checking bench of the reclose shot sequencer
// Assumes: TICK_CYCLES shortened to 4 so timers stay short
// Notes:   Expectations come from the shot settings chosen here
`timescale 1ns/1ps
`default_nettype none
module brs_sequencer_tb;
	logic SYS_CLK = 0, RSTN = 0;
	logic [4:0][4:0] SHOT_EN = '0, SHOT_DISCR = '0;
	logic [4:0][4:0][21:0] SHOT_START_DLY = '0, SHOT_DEAD = '0, SHOT_ACTION = '0;
	logic [4:0][4:0][21:0] SHOT_RECLAIM = '0;
	logic [21:0] LOCKOUT_TIME = '0, GEN_RECLAIM_TIME = '0;
	logic [1:0] RESET_MODE = '0;
	logic [4:0] REQ_START = '0, REQ_TRIP = '0, TRIP_DELAY_NZ = '0, SHOT_EXEC;
	logic GEN_RECLAIM_EN = 0, CRIT_REQ = 0, BLOCK_IN = 0, RECLOSE_ENABLE_INPUT = 1;
	logic LOCK_INPUT = 0, RESET_IN = 0, RESET_CMD = 0, OBJ_CLOSE_ANY = 0, OBJ_MAN_CLOSE = 0;
	logic OBJ_CMD_BLOCKED = 0, OBJ_OPEN, OBJ_CLOSED, OBJ_BAD = 0, OBJ_FAULT = 0;
	logic OPEN_CMD, CLOSE_CMD, FINAL_TRIP, READY, INHIBIT, LOCKED, RUNNING;
	logic [2:0] REQ_SEL;
	logic [3:0] REASON;
	logic [31:0] seed = 32'hA3FF771D;
	logic [5:0] ev;
	localparam int TICK = 4;
	int errors = 0, compares = 0, r, q, last_n;
	assign ev = {~CLOSE_CMD, ~RUNNING, ~LOCKED, LOCKED, CLOSE_CMD, OPEN_CMD};
	always #25 SYS_CLK = ~SYS_CLK;
	brs_sequencer #(.TICK_CYCLES(TICK)) dut (.*);
	brs_breaker_model #(.DLY(3)) far (.clk(SYS_CLK), .rstn(RSTN), .open_cmd(OPEN_CMD),
		.close_cmd(CLOSE_CMD), .obj_open(OBJ_OPEN), .obj_closed(OBJ_CLOSED));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Reference pick of the next enabled shot of a request, -1 when none is left
	function automatic int nxt(input int rq, input int from);
		int s;
		s = -1;
		for (int i = 4; i >= from; i--)
			if (SHOT_EN[rq][i])
				s = i;
		return s;
	endfunction : nxt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait on one event bit, sampled at the falling edge
	task automatic wt(input int i);
		int n;
		n = 0;
		do begin
			@(negedge SYS_CLK);
			n++;
		end while (ev[i] !== 1'b1 && n < 4000);
		last_n = n;
		chk(n < 4000, 1);
	endtask : wt
	task automatic summarize();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (30000) @(posedge SYS_CLK);
		errors++;
		summarize();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		r = xs() % 5;
		SHOT_EN[r] = 5'h02;
		SHOT_DEAD[r][1] = 22'(xs() % 4 + 1);
		SHOT_RECLAIM[r][1] = 22'h000004; // Later shot keeps zero start delay
		q = (r + 1) % 5;
		SHOT_EN[q] = 5'h01;
		SHOT_START_DLY[q][0] = 22'h000002;
		SHOT_DEAD[q][0] = 22'h000001;
		SHOT_ACTION[q][0] = 22'h000002;
		SHOT_RECLAIM[q][0] = 22'h000006;
		GEN_RECLAIM_TIME = 22'h000008;
		repeat (20) @(posedge SYS_CLK);
		RSTN <= 1'b1;
		repeat (2) @(negedge SYS_CLK);
		chk(READY, 1);
		@(posedge SYS_CLK) REQ_TRIP[r] <= 1'b1;
		wt(0);
		chk(SHOT_EXEC, 1 << nxt(r, 0));
		chk(REQ_SEL, r);
		@(posedge SYS_CLK) REQ_TRIP[r] <= 1'b0;
		wt(1);
		// Four cycles of breaker stroke and two register stages around the dead time
		chk(last_n, 6 + TICK * SHOT_DEAD[r][1]);
		wt(4);
		chk(LOCKED, 0);
		@(posedge SYS_CLK) REQ_TRIP[r] <= 1'b1;
		wt(0);
		@(posedge SYS_CLK) REQ_TRIP[r] <= 1'b0;
		wt(1);
		wt(5);
		@(posedge SYS_CLK) REQ_TRIP[r] <= 1'b1;
		wt(2);
		chk(FINAL_TRIP, nxt(r, 2) < 0);
		chk(REASON, brs_pkg::R_FINAL);
		// Let the breaker finish opening before the lock is reset
		repeat (6) @(negedge SYS_CLK);
		chk({OBJ_OPEN, OPEN_CMD}, 2'b10);
		@(posedge SYS_CLK) REQ_TRIP[r] <= 1'b0;
		RESET_IN <= 1'b1;
		wt(3);
		chk(FINAL_TRIP, 0);
		@(posedge SYS_CLK) RESET_IN <= 1'b0;
		RESET_MODE <= brs_pkg::RM_CMD;
		CRIT_REQ <= 1'b1;
		@(posedge SYS_CLK) CRIT_REQ <= 1'b0;
		wt(2);
		chk(REASON, brs_pkg::R_CRIT);
		@(posedge SYS_CLK) RESET_IN <= 1'b1;
		repeat (3) @(negedge SYS_CLK);
		chk(LOCKED, 1);
		@(posedge SYS_CLK) RESET_IN <= 1'b0;
		RESET_CMD <= 1'b1;
		wt(3);
		@(posedge SYS_CLK) RESET_CMD <= 1'b0;
		RESET_MODE <= brs_pkg::RM_CLOSE;
		LOCK_INPUT <= 1'b1;
		@(posedge SYS_CLK) LOCK_INPUT <= 1'b0;
		wt(2);
		chk(REASON, brs_pkg::R_LOCK_IN);
		@(posedge SYS_CLK) OBJ_CLOSE_ANY <= 1'b1;
		wt(3);
		@(posedge SYS_CLK) OBJ_CLOSE_ANY <= 1'b0;
		BLOCK_IN <= 1'b1;
		repeat (2) @(negedge SYS_CLK);
		chk(INHIBIT, 1);
		chk(REASON, brs_pkg::R_BLOCKED);
		@(posedge SYS_CLK) BLOCK_IN <= 1'b0;
		repeat (2) @(negedge SYS_CLK);
		chk(READY, 1);
		@(posedge SYS_CLK) GEN_RECLAIM_EN <= 1'b1;
		REQ_START[q] <= 1'b1;
		wt(0);
		chk(last_n, 3 + TICK * SHOT_START_DLY[q][0]);
		@(posedge SYS_CLK) REQ_START[q] <= 1'b0;
		wt(1);
		wt(5);
		@(posedge SYS_CLK) REQ_START[q] <= 1'b1;
		wt(2);
		chk(OBJ_CLOSED, 1);
		chk(REASON, brs_pkg::R_ARC_LOCK);
		@(posedge SYS_CLK) REQ_START[q] <= 1'b0;
		wt(3);
		chk(REASON, brs_pkg::R_GREC);
		@(posedge SYS_CLK) REQ_TRIP[q] <= 1'b1;
		wt(2);
		chk(REASON, brs_pkg::R_GREC_REQ);
		summarize();
	end
endmodule : brs_sequencer_tb
`default_nettype wire
